/* include/airc_consts.svh */
`ifndef AIRC_CONSTS_SVH
`define AIRC_CONSTS_SVH

// register byte offsets
`define AIRC_CTRL_OFS 8'h00
`define AIRC_STATUS_OFS 8'h04
`define AIRC_MASK_OFS 8'h08
`define AIRC_STATE_OFS 8'h0c
`define AIRC_SLEEP_OFS 8'h10

// control register fields
`define AIRC_CTRL_W 9
`define AIRC_CTRL_PRE 0
`define AIRC_CTRL_DIFFA 1
`define AIRC_CTRL_PDIFF 2
`define AIRC_CTRL_RMT 5
`define AIRC_CTRL_TXCMD 6
`define AIRC_CTRL_RST 9'h000

// status and mask fields
`define AIRC_EVT_W 4
`define AIRC_EVT_WAKE 0
`define AIRC_EVT_LOC 1
`define AIRC_EVT_RMT 2
`define AIRC_EVT_OVR 3
`define AIRC_EVT_RST 4'h0

// state and sleep register fields
`define AIRC_STATE_MODE 0
`define AIRC_STATE_LINK 1
`define AIRC_STATE_SEL 4
`define AIRC_SLEEP_GO 0

// bus answers
`define AIRC_RESP_OKAY 2'h0
`define AIRC_RESP_SLVERR 2'h2

// converter and result storage
`define AIRC_NUM_INPUTS 11
`define AIRC_DECIM_RATIO 64
`define AIRC_RAM_BASE 8'h00
`define AIRC_RAM_SHIFT 9

// remote link timing
`define AIRC_CLK_NS 20
`define AIRC_LINK_PERIOD_NS 400
`define AIRC_LINK_PULSE_NS 300
`define AIRC_LINK_PERIOD_CYC \
  ((`AIRC_LINK_PERIOD_NS + `AIRC_CLK_NS - 1) / `AIRC_CLK_NS)
`define AIRC_LINK_PULSE_CYC (`AIRC_LINK_PULSE_NS / `AIRC_CLK_NS)
`define AIRC_LINK_CNT_W 8

`endif

/* include/airc_pkg.sv */
`include "airc_consts.svh"

package airc_pkg;

  typedef enum logic [0:0] {
    AIRC_RUN = 1'b0,
    AIRC_SLEEP = 1'b1
  } airc_mode_type;

  typedef enum logic [0:0] {
    AIRC_DRIVE = 1'b0,
    AIRC_LISTEN = 1'b1
  } airc_link_type;

  typedef struct packed {
    logic valid;
    logic level;
  } airc_adc_type;

  typedef struct packed {
    logic [3:0] sel;
    logic diff;
    logic preamp;
  } airc_mux_type;

  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe;
  } airc_pin_drv_type;

  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [31:0] data;
  } airc_ram_wr_type;

  typedef struct packed {
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [`AIRC_CTRL_W-1:0] ctrl;
    logic [`AIRC_EVT_W-1:0] status;
    logic [`AIRC_EVT_W-1:0] mask;
    logic irq;
    airc_mode_type mode;
    logic pb_prev;
    airc_mux_type mux;
    logic loc_pend;
    logic [3:0] loc_addr;
    logic [31:0] loc_data;
    logic [2:0] rmt_pend;
    logic [2:0][31:0] rmt_data;
    airc_ram_wr_type ram;
    logic [`AIRC_LINK_CNT_W-1:0] link_cnt;
    airc_link_type link_phase;
    logic link_pol;
    logic rmt_bv;
    logic [2:0] rmt_bits;
    airc_pin_drv_type pins;
  } airc_state_type;

endpackage : airc_pkg

/* hdl/airc_decim.sv */
`timescale 1ns/100ps

module airc_decim #(
  parameter int RATIO = 64,
  parameter int OUT_W = 8
) (
  input wire logic aclk,
  input wire logic clear,
  input wire logic in_valid,
  input wire logic in_level,
  output logic out_valid,
  output logic [OUT_W-1:0] out_data
);
  import airc_pkg::*;

  localparam int CNT_W = $clog2(RATIO);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(RATIO - 1);
  localparam logic [OUT_W-1:0] PLUS = {{(OUT_W-1){1'b0}}, 1'b1};
  localparam logic [OUT_W-1:0] MINUS = {OUT_W{1'b1}};

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [OUT_W-1:0] acc;
    logic valid;
    logic [OUT_W-1:0] data;
  } airc_decim_state_type;

  airc_decim_state_type s_ff;
  airc_decim_state_type nxt_s;
  logic [OUT_W-1:0] sum;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.valid = 1'b0;
    // each modulator bit counts as plus or minus one
    sum = s_ff.acc + (in_level ? PLUS : MINUS);
    if (in_valid) begin
      if (s_ff.cnt == LAST) begin
        nxt_s.data = sum;
        nxt_s.valid = 1'b1;
        nxt_s.acc = '0;
        nxt_s.cnt = '0;
      end else begin
        nxt_s.acc = sum;
        nxt_s.cnt = s_ff.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (clear) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign out_valid = s_ff.valid;
  assign out_data = s_ff.data;

endmodule : airc_decim

/* hdl/airc_routing_ctrl.sv */
`timescale 1ns/100ps
// Functional notes
// - chip reset pin high holds everything at reset; low runs normally.
// - pushbutton rising edge sets the button wake flag.
// - pushbutton rising edge also leaves sleep mode.
// - local inputs reach the single converter through the input multiplexer.
// - converter output is decimated and written to compute-engine RAM.
// - remote sensor bits bypass the multiplexer into three dedicated decimators, one per remote pair.
// - remote results go straight to their RAM slot, no multiplexer slot used.
// - eleven inputs: eight current, three single-ended line voltage.
// - current inputs work as eight single-ended inputs or four differential pairs.
// - first pair pins are each selectable single-ended or differential.
// - preamp enable routes the first pair through the gain-8 preamp.
// - first pair differential enable makes the first pair differential.
// - remote enable turns remaining six pins into digital balanced pairs.
// - remote enable clear keeps the remaining six pins as analog inputs.
// - the first pair never acts as a remote interface.
// - bidirectional data with the remote sensor over the transformer.
// - dc power reaches the remote sensor as pulses over the transformer.

module airc_routing_ctrl #(
  parameter int DECIM_RATIO = `AIRC_DECIM_RATIO,
  parameter int DECIM_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic chip_reset_pin,
  input wire logic pushbutton_input,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire airc_pkg::airc_adc_type adc,
  output airc_pkg::airc_mux_type mux_ctl,
  output logic preamp_enable,
  output logic first_pair_differential_enable,
  output logic remote_sensor_enable,
  input wire logic [5:0] link_pin_in,
  output airc_pkg::airc_pin_drv_type link_pins,
  output airc_pkg::airc_ram_wr_type ram_wr,
  output logic sleep_state,
  output logic irq
);
  import airc_pkg::*;

  localparam logic [`AIRC_LINK_CNT_W-1:0] LINK_LAST =
    `AIRC_LINK_CNT_W'(`AIRC_LINK_PERIOD_CYC - 1);
  localparam logic [`AIRC_LINK_CNT_W-1:0] LINK_PULSE =
    `AIRC_LINK_CNT_W'(`AIRC_LINK_PULSE_CYC);

  airc_state_type s_ff;
  airc_state_type nxt_s;
  logic srst;
  logic loc_ov;
  logic [DECIM_W-1:0] loc_od;
  logic [2:0] rmt_ov;
  logic [2:0][DECIM_W-1:0] rmt_od;
  logic rmt_clear;
  logic [`AIRC_EVT_W-1:0] evt;
  logic wr_go;
  logic rd_go;
  logic [31:0] rd_val;
  logic [1:0] rd_resp;
  logic done;

  // the chip reset pin acts like the bus reset
  assign srst = !aresetn || chip_reset_pin;

  function automatic logic [31:0] ram_word(input logic [DECIM_W-1:0] d);
    ram_word = {{(32 - DECIM_W - `AIRC_RAM_SHIFT){d[DECIM_W-1]}}, d,
                {`AIRC_RAM_SHIFT{1'b0}}};
  endfunction : ram_word

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0] strb);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merge[b*8 +: 8] = val[b*8 +: 8];
      end
    end
  endfunction : merge

  // whether a multiplexer slot converts under the current routing
  function automatic logic ch_active(input logic [3:0] c,
                                     input logic [`AIRC_CTRL_W-1:0] ctrl);
    logic [1:0] p;
    p = 2'((c - 4'h2) >> 1);
    ch_active = 1'b1;
    if (c == 4'h1) begin
      ch_active = !ctrl[`AIRC_CTRL_DIFFA];
    end else if (c >= 4'h2 && c <= 4'h7) begin
      if (ctrl[`AIRC_CTRL_RMT]) begin
        ch_active = 1'b0;
      end else if (c[0]) begin
        ch_active = !ctrl[`AIRC_CTRL_PDIFF + int'(p)];
      end
    end else if (c >= 4'(`AIRC_NUM_INPUTS)) begin
      ch_active = 1'b0;
    end
  endfunction : ch_active

  function automatic logic [3:0] next_ch(input logic [3:0] cur,
                                         input logic [`AIRC_CTRL_W-1:0] ctrl);
    logic [3:0] cand;
    logic found;
    cand = cur;
    found = 1'b0;
    next_ch = cur;
    for (int i = 1; i <= `AIRC_NUM_INPUTS; i++) begin
      cand = 4'((32'(cur) + i) % `AIRC_NUM_INPUTS);
      if (!found && ch_active(cand, ctrl)) begin
        next_ch = cand;
        found = 1'b1;
      end
    end
  endfunction : next_ch

  airc_decim #(
    .RATIO(DECIM_RATIO),
    .OUT_W(DECIM_W)
  ) u_loc_decim (
    .aclk(aclk),
    .clear(srst),
    .in_valid(adc.valid && s_ff.mode == AIRC_RUN),
    .in_level(adc.level),
    .out_valid(loc_ov),
    .out_data(loc_od)
  );

  assign rmt_clear = srst || !s_ff.ctrl[`AIRC_CTRL_RMT];

  for (genvar k = 0; k < 3; k++) begin : g_rmt
    airc_decim #(
      .RATIO(DECIM_RATIO),
      .OUT_W(DECIM_W)
    ) u_rmt_decim (
      .aclk(aclk),
      .clear(rmt_clear),
      .in_valid(s_ff.rmt_bv),
      .in_level(s_ff.rmt_bits[k]),
      .out_valid(rmt_ov[k]),
      .out_data(rmt_od[k])
    );
  end

  always_comb begin
    nxt_s = s_ff;
    evt = '0;
    rd_val = 32'h0000_0000;
    rd_resp = `AIRC_RESP_OKAY;
    done = 1'b0;

    // write address and data are taken in either order
    if (awvalid && s_ff.awready) begin
      nxt_s.aw_have = 1'b1;
      nxt_s.aw_addr = awaddr;
    end
    if (wvalid && s_ff.wready) begin
      nxt_s.w_have = 1'b1;
      nxt_s.w_data = wdata;
      nxt_s.w_strb = wstrb;
    end
    if (bvalid && bready) begin
      nxt_s.bvalid = 1'b0;
    end
    wr_go = s_ff.aw_have && s_ff.w_have && !s_ff.bvalid;
    if (wr_go) begin
      nxt_s.aw_have = 1'b0;
      nxt_s.w_have = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = `AIRC_RESP_OKAY;
      if (s_ff.aw_addr == `AIRC_CTRL_OFS) begin
        nxt_s.ctrl = `AIRC_CTRL_W'(merge(32'(s_ff.ctrl), s_ff.w_data, s_ff.w_strb));
      end else if (s_ff.aw_addr == `AIRC_MASK_OFS) begin
        nxt_s.mask = `AIRC_EVT_W'(merge(32'(s_ff.mask), s_ff.w_data, s_ff.w_strb));
      end else if (s_ff.aw_addr == `AIRC_SLEEP_OFS) begin
        if (s_ff.w_strb[0] && s_ff.w_data[`AIRC_SLEEP_GO]) begin
          nxt_s.mode = AIRC_SLEEP;
        end
      end else if (s_ff.aw_addr == `AIRC_STATUS_OFS
                   || s_ff.aw_addr == `AIRC_STATE_OFS) begin
        nxt_s.bresp = `AIRC_RESP_OKAY;
      end else begin
        nxt_s.bresp = `AIRC_RESP_SLVERR;
      end
    end
    nxt_s.awready = !nxt_s.aw_have && !nxt_s.bvalid && !wr_go;
    nxt_s.wready = !nxt_s.w_have && !nxt_s.bvalid && !wr_go;

    // read path; a status read clears the sticky bits
    rd_go = arvalid && s_ff.arready;
    if (araddr == `AIRC_CTRL_OFS) begin
      rd_val = 32'(s_ff.ctrl);
    end else if (araddr == `AIRC_STATUS_OFS) begin
      rd_val = 32'(s_ff.status);
    end else if (araddr == `AIRC_MASK_OFS) begin
      rd_val = 32'(s_ff.mask);
    end else if (araddr == `AIRC_STATE_OFS) begin
      rd_val[`AIRC_STATE_MODE] = s_ff.mode;
      rd_val[`AIRC_STATE_LINK] = s_ff.link_phase;
      rd_val[`AIRC_STATE_SEL +: 4] = s_ff.mux.sel;
    end else if (araddr == `AIRC_SLEEP_OFS) begin
      rd_val[`AIRC_SLEEP_GO] = s_ff.mode;
    end else begin
      rd_resp = `AIRC_RESP_SLVERR;
    end
    if (rvalid && rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (rd_go) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rdata = rd_val;
      nxt_s.rresp = rd_resp;
      if (araddr == `AIRC_STATUS_OFS) begin
        nxt_s.status = '0;
      end
    end
    nxt_s.arready = !nxt_s.rvalid;

    // pushbutton edge wakes the device and flags it
    nxt_s.pb_prev = pushbutton_input;
    if (pushbutton_input && !s_ff.pb_prev) begin
      evt[`AIRC_EVT_WAKE] = 1'b1;
      nxt_s.mode = AIRC_RUN;
    end

    // multiplexer: current pair, then pairs or single pins, then voltages
    if (!ch_active(s_ff.mux.sel, s_ff.ctrl)) begin
      nxt_s.mux.sel = next_ch(s_ff.mux.sel, s_ff.ctrl);
    end else if (loc_ov) begin
      nxt_s.mux.sel = next_ch(s_ff.mux.sel, s_ff.ctrl);
    end
    nxt_s.mux.preamp = s_ff.ctrl[`AIRC_CTRL_PRE] && nxt_s.mux.sel < 4'h2;
    nxt_s.mux.diff = 1'b0;
    if (nxt_s.mux.sel == 4'h0) begin
      nxt_s.mux.diff = s_ff.ctrl[`AIRC_CTRL_DIFFA];
    end else if (nxt_s.mux.sel >= 4'h2 && nxt_s.mux.sel <= 4'h7
                 && !nxt_s.mux.sel[0]) begin
      nxt_s.mux.diff = s_ff.ctrl[`AIRC_CTRL_PDIFF + int'((nxt_s.mux.sel - 4'h2) >> 1)];
    end

    // one RAM write per cycle; local results first
    nxt_s.ram.en = 1'b0;
    if (s_ff.loc_pend) begin
      nxt_s.ram.en = 1'b1;
      nxt_s.ram.addr = `AIRC_RAM_BASE + {4'h0, s_ff.loc_addr};
      nxt_s.ram.data = s_ff.loc_data;
      nxt_s.loc_pend = 1'b0;
    end else begin
      for (int k = 2; k >= 0; k--) begin
        if (s_ff.rmt_pend[k]) begin
          nxt_s.ram.en = 1'b1;
          nxt_s.ram.addr = `AIRC_RAM_BASE + 8'(2 * k + 2);
          nxt_s.ram.data = s_ff.rmt_data[k];
          nxt_s.rmt_pend = s_ff.rmt_pend & ~(3'h1 << k);
        end
      end
    end
    if (loc_ov) begin
      evt[`AIRC_EVT_LOC] = 1'b1;
      if (nxt_s.loc_pend) begin
        evt[`AIRC_EVT_OVR] = 1'b1;
      end
      nxt_s.loc_pend = 1'b1;
      nxt_s.loc_addr = s_ff.mux.sel;
      nxt_s.loc_data = ram_word(loc_od);
    end
    for (int k = 0; k < 3; k++) begin
      if (rmt_ov[k]) begin
        evt[`AIRC_EVT_RMT] = 1'b1;
        if (nxt_s.rmt_pend[k]) begin
          evt[`AIRC_EVT_OVR] = 1'b1;
        end
        nxt_s.rmt_pend[k] = 1'b1;
        nxt_s.rmt_data[k] = ram_word(rmt_od[k]);
      end
    end

    // remote link: drive power pulses, then listen for one modulator bit
    nxt_s.rmt_bv = 1'b0;
    if (s_ff.ctrl[`AIRC_CTRL_RMT] && s_ff.mode == AIRC_RUN) begin
      nxt_s.link_cnt = (s_ff.link_cnt == LINK_LAST) ? '0 : s_ff.link_cnt + 1'b1;
      if (s_ff.link_cnt == LINK_LAST) begin
        nxt_s.link_pol = !s_ff.link_pol;
        nxt_s.rmt_bv = 1'b1;
        for (int k = 0; k < 3; k++) begin
          nxt_s.rmt_bits[k] = link_pin_in[2 * k];
        end
      end
      nxt_s.link_phase = (nxt_s.link_cnt < LINK_PULSE) ? AIRC_DRIVE : AIRC_LISTEN;
      for (int k = 0; k < 3; k++) begin
        // pulse polarity alternates for power; the command bit flips it
        nxt_s.pins.out[2 * k] = nxt_s.link_pol
                                ^ s_ff.ctrl[`AIRC_CTRL_TXCMD + k];
        nxt_s.pins.out[2 * k + 1] = !nxt_s.pins.out[2 * k];
      end
      nxt_s.pins.oe = (nxt_s.link_phase == AIRC_DRIVE) ? 6'h3f : 6'h00;
    end else begin
      nxt_s.link_cnt = '0;
      nxt_s.link_phase = AIRC_DRIVE;
      nxt_s.pins.out = 6'h00;
      nxt_s.pins.oe = 6'h00;
    end

    // events are sticky; a set in the clearing cycle survives
    nxt_s.status = nxt_s.status | evt;
    done = |(nxt_s.status & nxt_s.mask);
    nxt_s.irq = done;
  end

  always_ff @(posedge aclk) begin
    if (srst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign awready = s_ff.awready;
  assign wready = s_ff.wready;
  assign bvalid = s_ff.bvalid;
  assign bresp = s_ff.bresp;
  assign arready = s_ff.arready;
  assign rvalid = s_ff.rvalid;
  assign rresp = s_ff.rresp;
  assign rdata = s_ff.rdata;
  assign mux_ctl = s_ff.mux;
  // the first pair has no link pins, so it can never turn remote
  assign link_pins = s_ff.pins;
  assign ram_wr = s_ff.ram;
  assign preamp_enable = s_ff.ctrl[`AIRC_CTRL_PRE];
  assign first_pair_differential_enable = s_ff.ctrl[`AIRC_CTRL_DIFFA];
  assign remote_sensor_enable = s_ff.ctrl[`AIRC_CTRL_RMT];
  assign sleep_state = s_ff.mode;
  assign irq = s_ff.irq;

endmodule : airc_routing_ctrl

/* testbench/airc_routing_ctrl_asserts.sv */
`timescale 1ns/100ps

module airc_routing_ctrl_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic chip_reset_pin,
  input wire logic pushbutton_input,
  input wire airc_pkg::airc_mux_type mux_ctl,
  input wire logic preamp_enable,
  input wire logic first_pair_differential_enable,
  input wire logic remote_sensor_enable,
  input wire airc_pkg::airc_pin_drv_type link_pins,
  input wire airc_pkg::airc_ram_wr_type ram_wr,
  input wire logic sleep_state,
  input wire logic irq
);
  import airc_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || chip_reset_pin);

  AST_CHIP_RESET: assert property (disable iff (!aresetn) chip_reset_pin |=> !preamp_enable &&
    !remote_sensor_enable && !sleep_state && !irq && !ram_wr.en) else $error("chip reset ignored");
  AST_RESET_CLEAR: assert property (disable iff (chip_reset_pin) !aresetn |=> !preamp_enable &&
    !first_pair_differential_enable && !remote_sensor_enable && link_pins.oe == 6'h00)
    else $error("enables not clear after reset");
  AST_PB_WAKE: assert property ($rose(pushbutton_input) && sleep_state |=> !sleep_state)
    else $error("no wake on button");
  AST_LINK_OWNER: assert property (link_pins.oe != 6'h00 |->
    remote_sensor_enable || $past(remote_sensor_enable)) else $error("link driven while local");
  AST_LINK_PAIRS: assert property (link_pins.oe == 6'h3f |-> (link_pins.out[0] ^ link_pins.out[1]) &&
    (link_pins.out[2] ^ link_pins.out[3]) && (link_pins.out[4] ^ link_pins.out[5]))
    else $error("link pair not balanced");
  AST_LINK_LISTEN: assert property ($fell(link_pins.oe[0]) && remote_sensor_enable |->
    (link_pins.oe == 6'h00)[*5]) else $error("listen window too short");
  AST_PREAMP_SLOT: assert property (mux_ctl.preamp |-> mux_ctl.sel < 4'h2)
    else $error("preamp outside first pair");
  AST_DIFF_SLOT: assert property (mux_ctl.diff |-> mux_ctl.sel inside {4'h0, 4'h2, 4'h4, 4'h6})
    else $error("differential on odd slot");
  AST_SEL_RANGE: assert property (mux_ctl.sel < 4'hb) else $error("slot beyond inputs");
  AST_RAM_ALIGN: assert property (ram_wr.en |-> ram_wr.data[8:0] == 9'h000 && ram_wr.addr < 8'h0b)
    else $error("result store malformed");

  cover property (ram_wr.en && remote_sensor_enable);
  cover property ($rose(pushbutton_input) && sleep_state);
  cover property (mux_ctl.preamp);
endmodule : airc_routing_ctrl_chk

bind airc_routing_ctrl airc_routing_ctrl_chk u_airc_routing_ctrl_chk (.aclk(aclk),
  .aresetn(aresetn), .chip_reset_pin(chip_reset_pin), .pushbutton_input(pushbutton_input),
  .mux_ctl(mux_ctl), .preamp_enable(preamp_enable),
  .first_pair_differential_enable(first_pair_differential_enable),
  .remote_sensor_enable(remote_sensor_enable), .link_pins(link_pins), .ram_wr(ram_wr),
  .sleep_state(sleep_state), .irq(irq));

/* testbench/airc_remote_model.sv */
`timescale 1ns/100ps

module airc_remote_model (
  input wire logic aclk,
  input wire airc_pkg::airc_pin_drv_type link_pins,
  input wire logic [2:0] level,
  input wire logic slow,
  output logic [5:0] pin_in
);
  import airc_pkg::*;
  logic [7:0] quiet_ff = 8'hff;
  logic [5:0] junk_ff = 6'h2a;
  logic answer;
  // sensor lives on drive pulses; long without them it falls silent
  always @(posedge aclk) begin
    junk_ff <= ~junk_ff ^ 6'h15;
    if (link_pins.oe != 6'h00) quiet_ff <= 8'h00;
    else if (quiet_ff != 8'hff) quiet_ff <= quiet_ff + 8'h01;
  end
  assign answer = quiet_ff >= (slow ? 8'h03 : 8'h01) && quiet_ff < 8'h08;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pin_in[i] = link_pins.oe[i] ? link_pins.out[i] : answer ? level[i/2] ^ (i % 2 == 1) : junk_ff[i];
    end
  end
endmodule : airc_remote_model

/* testbench/tb_airc_routing_ctrl.sv */
`timescale 1ns/100ps
`include "airc_consts.svh"

module tb_airc_routing_ctrl;
  import airc_pkg::*;
  localparam int RATIO = 4;
  logic aclk = 1'b0, aresetn = 1'b0, chip_reset_pin = 1'b0, pushbutton_input = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, preamp_enable, first_pair_differential_enable;
  logic remote_sensor_enable, sleep_state, irq, slow = 1'b0;
  logic [1:0] bresp, rresp;
  airc_adc_type adc = '0;
  airc_mux_type mux_ctl;
  airc_pin_drv_type link_pins;
  airc_ram_wr_type ram_wr;
  logic [5:0] link_pin_in;
  logic [2:0] level = 3'h0;
  int errors = 0, total_checks = 0, seed = 21671, rcnt = 0, nbits = 0;
  logic [8:0] cfg = 9'h000;
  logic [3:0] sel = 4'h0;
  logic [7:0] acc = 8'h00;
  logic [39:0] expq[$];

  always #10 aclk = ~aclk;

  airc_routing_ctrl #(.DECIM_RATIO(RATIO)) u_airc_routing_ctrl (.aclk(aclk), .aresetn(aresetn),
    .chip_reset_pin(chip_reset_pin), .pushbutton_input(pushbutton_input), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .adc(adc), .mux_ctl(mux_ctl), .preamp_enable(preamp_enable),
    .first_pair_differential_enable(first_pair_differential_enable),
    .remote_sensor_enable(remote_sensor_enable), .link_pin_in(link_pin_in),
    .link_pins(link_pins), .ram_wr(ram_wr), .sleep_state(sleep_state), .irq(irq));

  airc_remote_model u_airc_remote_model (.aclk(aclk), .link_pins(link_pins), .level(level),
    .slow(slow), .pin_in(link_pin_in));

  function automatic logic [31:0] scaled(input logic [7:0] a);
    return {{24{a[7]}}, a} << 9;
  endfunction : scaled

  // slot that converts nothing under the given routing
  function automatic logic idle_sel(input logic [3:0] s, input logic [8:0] c);
    return (s == 4'h1 && c[1]) || (s >= 4'h2 && s <= 4'h7 && c[5]) ||
           (s inside {4'h3, 4'h5, 4'h7} && c[s/2+1]);
  endfunction : idle_sel

  function automatic logic [5:0] mux_exp(input logic [3:0] s, input logic [8:0] c);
    return {s, (s == 4'h0 && c[1]) || (s inside {4'h2, 4'h4, 4'h6} && c[s/2+1]),
            c[0] && s < 4'h2};
  endfunction : mux_exp

  function automatic logic [3:0] next_sel(input logic [3:0] s, input logic [8:0] c);
    do begin
      s = (s == 4'ha) ? 4'h0 : s + 4'h1;
    end while (idle_sel(s, c));
    return s;
  endfunction : next_sel

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    rready <= 1'b0;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    @(posedge aclk);
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, `AIRC_RESP_OKAY, d);
    chk("register", exp, d);
  endtask : rc

  task automatic bits(input int n);
    repeat (n * RATIO) begin
      @(posedge aclk);
      adc <= {1'b1, 1'($random(seed))};
    end
    @(posedge aclk);
    adc <= '0;
    for (int i = 0; i < 20 && expq.size() > 0; i++) @(posedge aclk);
    chk("results left", 32'h0, expq.size());
  endtask : bits

  // converter and result store reference model
  always @(posedge aclk) begin
    logic [39:0] e;
    if (ram_wr.en) begin
      if (expq.size() > 0 && expq[0][39:32] === ram_wr.addr) begin
        e = expq.pop_front();
        chk("local result", e[31:0], ram_wr.data);
        chk("mux", {26'h0, mux_exp(sel, cfg)}, {26'h0, mux_ctl});
      end else begin
        rcnt++;
        chk("remote result", scaled(level[ram_wr.addr[2:1]-2'h1] ? 8'(RATIO) : 8'(-RATIO)), ram_wr.data);
      end
    end
    if (adc.valid && !sleep_state && aresetn && !chip_reset_pin) begin
      acc = acc + (adc.level ? 8'h01 : 8'hff);
      nbits++;
      if (nbits == RATIO) begin
        expq.push_back({4'h0, sel, scaled(acc)});
        sel = next_sel(sel, cfg);
        acc = 8'h00;
        nbits = 0;
      end
    end
  end

  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    stop_test;
  end

  // production test input is held at ground by the system outside the block
  initial begin
    logic [31:0] d;
    logic [8:0] tbl [3] = '{9'h001, 9'h003, 9'h01e};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("enables", 32'h0, {29'h0, preamp_enable, first_pair_differential_enable, remote_sensor_enable});
    rc(`AIRC_CTRL_OFS, 32'h0);
    for (int i = 0; i < 6; i++) begin
      d = (i < 3) ? {23'h0, tbl[i]} : $random(seed) & 32'h1df;
      wr(`AIRC_CTRL_OFS, d, `AIRC_RESP_OKAY);
      cfg = d[8:0];
      // the design leaves a slot at once when the new routing disables it
      if (idle_sel(sel, cfg)) sel = next_sel(sel, cfg);
      rc(`AIRC_CTRL_OFS, d);
      chk("pair enables", {30'h0, d[1:0]}, {30'h0, first_pair_differential_enable, preamp_enable});
      bits(3);
    end
    wr(8'h20, 32'h1, `AIRC_RESP_SLVERR);
    rd(8'h20, `AIRC_RESP_SLVERR, d);
    chk("unmapped", 32'h0, d);
    rd(`AIRC_STATUS_OFS, `AIRC_RESP_OKAY, d);
    wr(`AIRC_SLEEP_OFS, 32'h1, `AIRC_RESP_OKAY);
    chk("sleep", 32'h1, {31'h0, sleep_state});
    rc(`AIRC_SLEEP_OFS, 32'h1);
    rc(`AIRC_STATE_OFS, {24'h0, sel, 4'h1});
    pushbutton_input <= 1'b1;
    repeat (2) @(posedge aclk);
    pushbutton_input <= 1'b0;
    @(posedge aclk);
    chk("sleep", 32'h0, {31'h0, sleep_state});
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`AIRC_MASK_OFS, 32'h1, `AIRC_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq", 32'h1, {31'h0, irq});
    rd(`AIRC_STATUS_OFS, `AIRC_RESP_OKAY, d);
    chk("wake flag", 32'h1, d & 32'h1);
    @(posedge aclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(`AIRC_CTRL_OFS, 32'h3, `AIRC_RESP_OKAY);
    chip_reset_pin <= 1'b1;
    repeat (2) @(posedge aclk);
    chip_reset_pin <= 1'b0;
    repeat (2) @(posedge aclk);
    cfg = 9'h000; sel = 4'h0; acc = 8'h00; nbits = 0;
    rc(`AIRC_CTRL_OFS, 32'h0);
    rc(`AIRC_MASK_OFS, 32'h0);
    level <= 3'($random(seed));
    d = {23'h0, 3'($random(seed)), 6'h22};
    wr(`AIRC_CTRL_OFS, d, `AIRC_RESP_OKAY);
    cfg = d[8:0];
    chk("remote on", 32'h1, {31'h0, remote_sensor_enable});
    bits(40);
    slow <= 1'b1;
    bits(40);
    chk("remote count", 32'h1, {31'h0, rcnt >= 9});
    wr(`AIRC_CTRL_OFS, 32'h0, `AIRC_RESP_OKAY);
    cfg = 9'h000;
    repeat (3) @(posedge aclk);
    chk("link released", 32'h0, {26'h0, link_pins.oe});
    stop_test;
  end
endmodule : tb_airc_routing_ctrl
